// file: hdl/bvs_pkg.sv
// Function
// RULE_01 - buck two register at 0x17, resets 0x8f
// RULE_02 - writes accepted only after valid unlock
// RULE_03 - buck two write blanks monitors 5 ms
// RULE_04 - buck two code applied only on strobe
// RULE_05 - bit 7 pulse-skip enable, resets to 1
// RULE_06 - bits 5:0 voltage code, resets 0x0f
// RULE_07 - buck three register at 0x18, resets 0x1f
// RULE_08 - buck three write blanks monitors 5 ms
// RULE_09 - buck three default chosen by select resistor
// RULE_10 - buck three bit 7 pulse-skip enable
// RULE_11 - buck three code bits 5:0, resets 0x1f
// RULE_12 - bit 6 reserved, reads zero, ignores writes
package bvs_pkg;

	localparam logic [7:0] BUCK_TWO_ADDR = 8'h17;
	localparam logic [7:0] BUCK_THREE_ADDR = 8'h18;
	localparam logic [7:0] APPLY_REG_ADDR = 8'h1a;

	localparam logic [7:0] BUCK_TWO_RST = 8'h8f;
	localparam logic [7:0] BUCK_THREE_RST = 8'h1f;
	// used when the select resistor is strapped high; value is a plain default
	localparam logic [7:0] BUCK_THREE_ALT_RST = 8'h9f;

	localparam int PSE_BIT = 7;
	localparam int RSVD_BIT = 6;
	localparam int CODE_LSB = 0;
	localparam int CODE_W = 6;

	localparam int BLANK_TIME_MS = 5;
	localparam int CLK_HZ = 50000000;
	localparam int BLANK_CYCLES = BLANK_TIME_MS * (CLK_HZ / 1000);

	localparam logic [11:0] TWO_BASE_MV = 12'h352;
	localparam logic [11:0] TWO_FINE_MV = 12'h00a;
	localparam logic [11:0] TWO_COARSE_MV = 12'h019;
	localparam logic [11:0] TWO_KNEE = 12'h032;
	localparam logic [11:0] THREE_BASE_MV = 12'h384;
	localparam logic [11:0] THREE_FINE_MV = 12'h019;
	localparam logic [11:0] THREE_COARSE_MV = 12'h032;
	localparam logic [11:0] THREE_KNEE = 12'h01a;

	typedef struct packed
	{
		logic pulse_skip_enable;
		logic rsvd;
		logic [CODE_W-1:0] code;
	} bvs_setting_t;

	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bvs_req_t;

	// fine steps up to the knee, coarse steps above it
	function automatic logic [11:0] bvs_two_mv(input logic [CODE_W-1:0] c);
		logic [11:0] cc;
		cc = {6'h00, c};
		if (cc <= TWO_KNEE)
			return TWO_BASE_MV + cc * TWO_FINE_MV;
		return TWO_BASE_MV + TWO_KNEE * TWO_FINE_MV + (cc - TWO_KNEE) * TWO_COARSE_MV;
	endfunction

	function automatic logic [11:0] bvs_three_mv(input logic [CODE_W-1:0] c);
		logic [11:0] cc;
		cc = {6'h00, c};
		if (cc <= THREE_KNEE)
			return THREE_BASE_MV + cc * THREE_FINE_MV;
		return THREE_BASE_MV + THREE_KNEE * THREE_FINE_MV + (cc - THREE_KNEE) * THREE_COARSE_MV;
	endfunction

endpackage

// file: hdl/bvs_blank_timer.sv
// monitor blanking window timer, restarts on every start pulse
`timescale 1ns/100ps
`default_nettype none
module bvs_blank_timer #(
	parameter int unsigned CYCLES = 250000,
	parameter int unsigned CNT_W = $clog2(CYCLES + 1)
) (
	input wire logic clk, // system clock
	input wire logic nrst, // synchronous reset, active low
	input wire logic start, // one-cycle pulse, (re)starts the window
	output logic busy // high while the window runs
);
	import bvs_pkg::*;

	localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES);

	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	wire running = cnt_r != '0;

	// a new write extends the window rather than being ignored
	assign cnt_nxt = start ? LOAD : (running ? cnt_r - 1'b1 : cnt_r);
	assign busy = running;

	always_ff @(posedge clk)
	begin
		if (!nrst)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	property p_blank_load;
		@(posedge clk) disable iff (!nrst)
		start |=> cnt_r == LOAD;
	endproperty
	a_blank_load: assert property (p_blank_load) else $error("blank window not loaded"); // RULE_03

	property p_blank_count;
		@(posedge clk) disable iff (!nrst)
		running && !start |=> cnt_r == $past(cnt_r) - 1'b1;
	endproperty
	a_blank_count: assert property (p_blank_count) else $error("blank window not counting"); // RULE_08

endmodule
`default_nettype wire

// file: hdl/bvs_regs.sv
// buck voltage setting registers with unlock gating, apply strobes and monitor blanking
`timescale 1ns/100ps
`default_nettype none
module bvs_regs #(
	parameter int unsigned BLANK_CYCLES = bvs_pkg::BLANK_CYCLES,
	parameter logic [7:0] THREE_ALT_RST = bvs_pkg::BUCK_THREE_ALT_RST
) (
	input wire logic CLK, // system clock, 50 MHz
	input wire logic NRST, // synchronous reset, active low
	input wire bvs_pkg::bvs_req_t REG_REQ, // register access from the serial interface
	output logic [7:0] REG_RDATA, // read data, valid with REG_RVALID
	output logic REG_RVALID, // one-cycle pulse after a read
	output logic REG_WR_REFUSED, // one-cycle pulse, locked write dropped
	input wire logic UNLOCK_VALID, // unlock sequence completed for this write
	input wire logic GO_STROBE, // apply strobe from the apply register
	input wire logic APPLY_WITH_DISCHARGE_STROBE, // apply-with-discharge strobe
	input wire logic DEFAULT_SELECT_RESISTOR, // default select strap level
	output logic [5:0] BUCK_TWO_VOLTAGE_CODE, // applied buck two code
	output logic [5:0] BUCK_THREE_VOLTAGE_CODE, // applied buck three code
	output logic [11:0] BUCK_TWO_MV, // applied buck two target in mV
	output logic [11:0] BUCK_THREE_MV, // applied buck three target in mV
	output logic BUCK_TWO_PULSE_SKIP, // buck two pulse-skip enable
	output logic BUCK_THREE_PULSE_SKIP, // buck three pulse-skip enable
	output logic BUCK_TWO_MON_BLANK, // buck two monitor blanking active
	output logic BUCK_THREE_MON_BLANK // buck three monitor blanking active
);
	import bvs_pkg::*;

	bvs_setting_t two_r;
	bvs_setting_t two_nxt;
	bvs_setting_t three_r;
	bvs_setting_t three_nxt;
	bvs_setting_t wr_val;
	logic [5:0] two_app_r;
	logic [5:0] two_app_nxt;
	logic [5:0] three_app_r;
	logic [5:0] three_app_nxt;
	logic [11:0] two_mv_r;
	logic [11:0] three_mv_r;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic rvalid_r;
	logic refused_r;
	logic blank_two;
	logic blank_three;

	// address decode
	wire hit_two = REG_REQ.addr == BUCK_TWO_ADDR;
	wire hit_three = REG_REQ.addr == BUCK_THREE_ADDR;
	wire hit_any = hit_two || hit_three;

	// both registers are protected; nothing lands without the unlock
	wire wr_ok = REG_REQ.wr && UNLOCK_VALID; // RULE_02
	wire wr_two = wr_ok && hit_two;
	wire wr_three = wr_ok && hit_three;
	wire wr_locked = REG_REQ.wr && hit_any && !UNLOCK_VALID; // RULE_02

	wire apply = GO_STROBE || APPLY_WITH_DISCHARGE_STROBE; // RULE_04

	// the reserved bit is forced to zero on every write
	assign wr_val = '{pulse_skip_enable: REG_REQ.wdata[PSE_BIT], rsvd: 1'b0,
		code: REG_REQ.wdata[CODE_LSB +: CODE_W]}; // RULE_12

	assign two_nxt = wr_two ? wr_val : two_r; // RULE_05 RULE_06
	assign three_nxt = wr_three ? wr_val : three_r; // RULE_10 RULE_11

	// a code written in the same cycle as the strobe is applied at once
	assign two_app_nxt = apply ? two_nxt.code : two_app_r; // RULE_04
	assign three_app_nxt = apply ? three_nxt.code : three_app_r;

	assign rdata_nxt = hit_two ? two_r : (hit_three ? three_r : 8'h00);

	// buck two register and its applied code
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			two_r <= BUCK_TWO_RST; // RULE_01
			two_app_r <= BUCK_TWO_RST[CODE_LSB +: CODE_W];
		end
		else
		begin
			two_r <= two_nxt;
			two_app_r <= two_app_nxt;
		end
	end

	// buck three default follows the strap, caught while reset is held
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			three_r <= DEFAULT_SELECT_RESISTOR ? THREE_ALT_RST : BUCK_THREE_RST; // RULE_07 RULE_09
			three_app_r <= DEFAULT_SELECT_RESISTOR ? THREE_ALT_RST[CODE_LSB +: CODE_W] :
				BUCK_THREE_RST[CODE_LSB +: CODE_W];
		end
		else
		begin
			three_r <= three_nxt;
			three_app_r <= three_app_nxt;
		end
	end

	// targets in mV follow the applied codes one cycle later
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			two_mv_r <= 12'h000;
			three_mv_r <= 12'h000;
		end
		else
		begin
			two_mv_r <= bvs_two_mv(two_app_r); // RULE_06
			three_mv_r <= bvs_three_mv(three_app_r); // RULE_11
		end
	end

	// read port and refusal flag
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
			refused_r <= 1'b0;
		end
		else
		begin
			rdata_r <= REG_REQ.rd ? rdata_nxt : rdata_r;
			rvalid_r <= REG_REQ.rd;
			refused_r <= wr_locked;
		end
	end

	// each accepted write restarts its own converter's blanking
	bvs_blank_timer #(
		.CYCLES(BLANK_CYCLES)
	) u_blank_two (
		.clk(CLK),
		.nrst(NRST),
		.start(wr_two), // RULE_03
		.busy(blank_two)
	);

	bvs_blank_timer #(
		.CYCLES(BLANK_CYCLES)
	) u_blank_three (
		.clk(CLK),
		.nrst(NRST),
		.start(wr_three), // RULE_08
		.busy(blank_three)
	);

	assign REG_RDATA = rdata_r;
	assign REG_RVALID = rvalid_r;
	assign REG_WR_REFUSED = refused_r;
	assign BUCK_TWO_VOLTAGE_CODE = two_app_r;
	assign BUCK_THREE_VOLTAGE_CODE = three_app_r;
	assign BUCK_TWO_MV = two_mv_r;
	assign BUCK_THREE_MV = three_mv_r;
	// pulse-skip takes effect without a strobe
	assign BUCK_TWO_PULSE_SKIP = two_r.pulse_skip_enable; // RULE_05
	assign BUCK_THREE_PULSE_SKIP = three_r.pulse_skip_enable; // RULE_10
	assign BUCK_TWO_MON_BLANK = blank_two;
	assign BUCK_THREE_MON_BLANK = blank_three;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);

	property p_two_reset;
		$rose(NRST) |-> two_r == BUCK_TWO_RST && two_app_r == 6'h0f;
	endproperty
	a_two_reset: assert property (p_two_reset) else $error("buck two reset value wrong"); // RULE_01

	property p_locked_write;
		wr_locked |=> $stable(two_r) && $stable(three_r) && REG_WR_REFUSED;
	endproperty
	a_locked_write: assert property (p_locked_write) else $error("locked write changed a register"); // RULE_02

	sequence s_two_write;
		wr_two;
	endsequence
	sequence s_two_blank;
		BUCK_TWO_MON_BLANK [*8];
	endsequence
	property p_two_blank;
		s_two_write |=> s_two_blank;
	endproperty
	a_two_blank: assert property (p_two_blank) else $error("buck two monitors not blanked"); // RULE_03

	property p_two_hold;
		!apply |=> $stable(BUCK_TWO_VOLTAGE_CODE);
	endproperty
	a_two_hold: assert property (p_two_hold) else $error("buck two code changed without strobe"); // RULE_04

	property p_two_apply;
		apply |=> BUCK_TWO_VOLTAGE_CODE == $past(two_nxt.code) ##1 BUCK_TWO_MV == bvs_two_mv($past(two_nxt.code, 2));
	endproperty
	a_two_apply: assert property (p_two_apply) else $error("buck two strobe not applied"); // RULE_04

	property p_two_write;
		wr_two |=> BUCK_TWO_PULSE_SKIP == $past(REG_REQ.wdata[7]) && two_r.code == $past(REG_REQ.wdata[5:0]);
	endproperty
	a_two_write: assert property (p_two_write) else $error("buck two write not stored"); // RULE_05

	property p_two_code_mv;
		apply && two_nxt.code == 6'h3f |=> ##1 BUCK_TWO_MV == 12'h68b;
	endproperty
	a_two_code_mv: assert property (p_two_code_mv) else $error("buck two top code target wrong"); // RULE_06

	property p_three_reset;
		$rose(NRST) && !$past(DEFAULT_SELECT_RESISTOR) |-> three_r == BUCK_THREE_RST;
	endproperty
	a_three_reset: assert property (p_three_reset) else $error("buck three reset value wrong"); // RULE_07

	sequence s_three_blank;
		BUCK_THREE_MON_BLANK [*8];
	endsequence
	property p_three_blank;
		wr_three |=> s_three_blank;
	endproperty
	a_three_blank: assert property (p_three_blank) else $error("buck three monitors not blanked"); // RULE_08

	property p_three_strap;
		$rose(NRST) && $past(DEFAULT_SELECT_RESISTOR) |-> three_r == THREE_ALT_RST;
	endproperty
	a_three_strap: assert property (p_three_strap) else $error("buck three strap default ignored"); // RULE_09

	property p_three_write;
		wr_three |=> BUCK_THREE_PULSE_SKIP == $past(REG_REQ.wdata[7]) && three_r.code == $past(REG_REQ.wdata[5:0]);
	endproperty
	a_three_write: assert property (p_three_write) else $error("buck three write not stored"); // RULE_10

	property p_three_code_mv;
		apply && three_nxt.code == 6'h3f |=> ##1 BUCK_THREE_MV == 12'hd48;
	endproperty
	a_three_code_mv: assert property (p_three_code_mv) else $error("buck three top code target wrong"); // RULE_11

	property p_reserved;
		REG_RVALID |-> !REG_RDATA[RSVD_BIT];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit read as one"); // RULE_12

	property p_rsvd_store;
		!two_r.rsvd && !three_r.rsvd;
	endproperty
	a_rsvd_store: assert property (p_rsvd_store) else $error("reserved bit stored as one"); // RULE_12

	property p_three_hold;
		!apply |=> $stable(BUCK_THREE_VOLTAGE_CODE);
	endproperty
	a_three_hold: assert property (p_three_hold) else $error("buck three code changed without strobe"); // RULE_11

	property p_three_apply;
		apply |=> BUCK_THREE_VOLTAGE_CODE == $past(three_nxt.code)
			##1 BUCK_THREE_MV == bvs_three_mv($past(three_nxt.code, 2));
	endproperty
	a_three_apply: assert property (p_three_apply) else $error("buck three strobe not applied"); // RULE_11

	property p_mv_follow;
		1'b1 |=> BUCK_TWO_MV == bvs_two_mv($past(BUCK_TWO_VOLTAGE_CODE));
	endproperty
	a_mv_follow: assert property (p_mv_follow) else $error("buck two target does not follow code"); // RULE_06

	property p_two_still;
		!wr_two |=> $stable(two_r);
	endproperty
	a_two_still: assert property (p_two_still) else $error("buck two changed without accepted write"); // RULE_02

	property p_three_still;
		!wr_three |=> $stable(three_r);
	endproperty
	a_three_still: assert property (p_three_still) else $error("buck three changed without accepted write"); // RULE_02

	property p_refused_only;
		!wr_locked |=> !REG_WR_REFUSED;
	endproperty
	a_refused_only: assert property (p_refused_only) else $error("refusal shown without locked write"); // RULE_02

	property p_read_two;
		REG_REQ.rd && hit_two |=> REG_RVALID && REG_RDATA == $past(two_r);
	endproperty
	a_read_two: assert property (p_read_two) else $error("buck two read data wrong"); // RULE_01

	property p_read_three;
		REG_REQ.rd && hit_three |=> REG_RVALID && REG_RDATA == $past(three_r);
	endproperty
	a_read_three: assert property (p_read_three) else $error("buck three read data wrong"); // RULE_07

	property p_two_quiet;
		!BUCK_TWO_MON_BLANK && !wr_two |=> !BUCK_TWO_MON_BLANK;
	endproperty
	a_two_quiet: assert property (p_two_quiet) else $error("buck two blanking without write"); // RULE_03

	property p_three_quiet;
		!BUCK_THREE_MON_BLANK && !wr_three |=> !BUCK_THREE_MON_BLANK;
	endproperty
	a_three_quiet: assert property (p_three_quiet) else $error("buck three blanking without write"); // RULE_08

	property p_two_skip_reset;
		$rose(NRST) |-> BUCK_TWO_PULSE_SKIP;
	endproperty
	a_two_skip_reset: assert property (p_two_skip_reset) else $error("buck two pulse-skip reset wrong"); // RULE_05

endmodule
`default_nettype wire

// file: verification/bvs_host_model.sv
// host side model: register requests, unlock level and apply strobes
`timescale 1ns/100ps
`default_nettype none
module bvs_host_model (
	input wire logic clk, // system clock
	output bvs_pkg::bvs_req_t req, // register request
	output logic unlock, // unlock level for the current write
	output logic go, // apply strobe
	output logic go_dis // apply-with-discharge strobe
);
	import bvs_pkg::*;
	initial
	begin
		req = '0;
		unlock = 1'b0;
		go = 1'b0;
		go_dis = 1'b0;
	end
	// a locked write is only sent when a test wants it refused
	task automatic write(input logic [7:0] a, input logic [7:0] d, input logic ok);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		unlock <= ok;
		@(posedge clk);
		req <= '0;
		unlock <= 1'b0;
	endtask
	task automatic read(input logic [7:0] a);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		req <= '0;
	endtask
	task automatic apply(input logic dis);
		@(posedge clk);
		go <= ~dis;
		go_dis <= dis;
		@(posedge clk);
		go <= 1'b0;
		go_dis <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: verification/bvs_regs_tb_top.sv
// self-checking bench for the buck voltage setting registers
`timescale 1ns/100ps
`default_nettype none
module bvs_regs_tb_top;
	import bvs_pkg::*;
	localparam int unsigned BLANK = 16;
	localparam logic [7:0] ALT_RST = 8'h9f;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic strap = 1'b0;
	bvs_req_t req;
	logic unlock, go, go_dis, rvalid, refused, ps2, ps3, blank2, blank3;
	logic [7:0] rdata, d;
	logic [5:0] code2, code3;
	logic [11:0] mv2, mv3;
	int err_count = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [7:0] rd_q[$];
	logic [5:0] c2[4] = '{6'h00, 6'h32, 6'h33, 6'h3f};
	logic [11:0] m2[4] = '{12'h352, 12'h546, 12'h55f, 12'h68b};
	logic [5:0] c3[4] = '{6'h00, 6'h1a, 6'h1b, 6'h3f};
	logic [11:0] m3[4] = '{12'h384, 12'h60e, 12'h640, 12'hd48};
	always #10 clk = ~clk;
	bvs_host_model i_bvs_host_model (.clk(clk), .req(req), .unlock(unlock), .go(go), .go_dis(go_dis));
	bvs_regs #(.BLANK_CYCLES(BLANK), .THREE_ALT_RST(ALT_RST)) i_bvs_regs (.CLK(clk), .NRST(nrst),
		.REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid), .REG_WR_REFUSED(refused),
		.UNLOCK_VALID(unlock), .GO_STROBE(go), .APPLY_WITH_DISCHARGE_STROBE(go_dis),
		.DEFAULT_SELECT_RESISTOR(strap), .BUCK_TWO_VOLTAGE_CODE(code2), .BUCK_THREE_VOLTAGE_CODE(code3),
		.BUCK_TWO_MV(mv2), .BUCK_THREE_MV(mv3), .BUCK_TWO_PULSE_SKIP(ps2), .BUCK_THREE_PULSE_SKIP(ps3),
		.BUCK_TWO_MON_BLANK(blank2), .BUCK_THREE_MON_BLANK(blank3));
	task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic finish_test();
		if (err_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// expected read data is queued; the monitor below pairs it with each answer
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		rd_q.push_back(exp);
		i_bvs_host_model.read(a);
	endtask
	always @(posedge clk)
		if (rvalid === 1'b1)
		begin
			if (rd_q.size() == 0)
				chk("spare read", 12'h001, 12'h000);
			else
				chk("rdata", {4'h0, rdata}, {4'h0, rd_q.pop_front()});
		end
	// window must hold exactly BLANK cycles after the accepted write
	task automatic blank_wr(input logic [7:0] a, input logic [7:0] v);
		i_bvs_host_model.write(a, v, 1'b1);
		#1;
		chk("refused", {11'h0, refused}, 12'h000);
		chk("blank on", {11'h0, (a == BUCK_TWO_ADDR) ? blank2 : blank3}, 12'h001);
		repeat (BLANK - 1) @(posedge clk);
		#1;
		chk("blank held", {11'h0, (a == BUCK_TWO_ADDR) ? blank2 : blank3}, 12'h001);
		@(posedge clk);
		#1;
		chk("blank off", {11'h0, (a == BUCK_TWO_ADDR) ? blank2 : blank3}, 12'h000);
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles > 3000)
		begin
			err_count++;
			finish_test();
		end
	end
	initial
	begin
		void'($urandom(32'h1693f793));
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("code2", {6'h0, code2}, 12'h00f);
		chk("code3", {6'h0, code3}, 12'h01f);
		chk("mv2", mv2, 12'h3e8);
		chk("mv3", mv3, 12'h708);
		chk("ps2", {11'h0, ps2}, 12'h001);
		rd(BUCK_TWO_ADDR, 8'h8f);
		rd(BUCK_THREE_ADDR, 8'h1f);
		rd(APPLY_REG_ADDR, 8'h00);
		i_bvs_host_model.write(BUCK_TWO_ADDR, 8'h00, 1'b0);
		#1;
		chk("refused", {11'h0, refused}, 12'h001);
		rd(BUCK_TWO_ADDR, 8'h8f);
		d = 8'($urandom) | 8'h40;
		blank_wr(BUCK_TWO_ADDR, d);
		chk("ps2", {11'h0, ps2}, {11'h0, d[7]});
		chk("code2 held", {6'h0, code2}, 12'h00f);
		rd(BUCK_TWO_ADDR, d & 8'hbf);
		d = 8'($urandom) | 8'h40;
		blank_wr(BUCK_THREE_ADDR, d);
		chk("ps3", {11'h0, ps3}, {11'h0, d[7]});
		rd(BUCK_THREE_ADDR, d & 8'hbf);
		for (int i = 0; i < 4; i++)
		begin
			i_bvs_host_model.write(BUCK_TWO_ADDR, {i[0], 1'b1, c2[i]}, 1'b1);
			i_bvs_host_model.write(BUCK_THREE_ADDR, {~i[0], 1'b0, c3[i]}, 1'b1);
			#1;
			chk("ps2", {11'h0, ps2}, {11'h0, i[0]});
			chk("ps3", {11'h0, ps3}, {11'h0, ~i[0]});
			i_bvs_host_model.apply(i[0]);
			#1;
			chk("code2", {6'h0, code2}, {6'h0, c2[i]});
			chk("code3", {6'h0, code3}, {6'h0, c3[i]});
			@(posedge clk);
			#1;
			chk("mv2", mv2, m2[i]);
			chk("mv3", mv3, m3[i]);
		end
		@(posedge clk);
		strap <= 1'b1;
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		rd(BUCK_THREE_ADDR, ALT_RST);
		rd(BUCK_TWO_ADDR, 8'h8f);
		repeat (2) @(posedge clk);
		#1;
		chk("code3 strap", {6'h0, code3}, {6'h0, ALT_RST[5:0]});
		chk("ps3 strap", {11'h0, ps3}, {11'h0, ALT_RST[7]});
		chk("ps2 reset", {11'h0, ps2}, 12'h001);
		chk("reads left", 12'(rd_q.size()), 12'h000);
		finish_test();
	end
endmodule
`default_nettype wire
